// file: src/tw16_wave_ctrl.v
// How it works
// [R1] Count and flags advance only on tick enable
// [R2] Dual-slope freq-correct loads compares at BOTTOM
// [R3] Control A: modes 7:6, 5:4, wave 1:0
// [R4] Nonzero output mode takes over the pin
// [R5] Software sets port direction to drive pin
// [R6] Output mode decode depends on wave mode
// [R7] Non-PWM: off, toggle, clear, set on match
// [R8] Fast PWM: match clear/set, BOTTOM opposite
// [R9] Fast PWM toggle only A in 14/15
// [R10] Fast PWM compare at TOP: match ignored
// [R11] Dual-slope: up and down matches opposite
// [R12] Dual-slope toggle only A in 9/11
// [R13] Wave mode from A low, B high; 13 reserved
// [R14] Mode 0: TOP FFFF, immediate, overflow at MAX
// [R15] Modes 1-3: phase correct fixed TOP
// [R16] Modes 5-7: fast PWM fixed TOP
// [R17] Modes 4/12: TOP from compare A/capture
// [R18] Modes 8/9: freq-correct, capture/A TOP
// [R19] Modes 10/11: phase correct, update at TOP
// [R20] Modes 14/15: fast PWM, update at BOTTOM
// [R21] High wave bits in control B 4:3
// [R22] Match flag set on tick after match
`timescale 1ns/1ps
`include "tw16_regs.vh"
module tw16_wave_ctrl (
    // Clock and reset
    input  wire        aclk,
    input  wire        aresetn,
    // AXI4-Lite write
    input  wire [4:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    // AXI4-Lite read
    input  wire [4:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // Timer tick enable, same clock domain
    input  wire        timer_tick_enable,
    // Compare outputs
    output reg         compare_out_a_pin,
    output reg         compare_out_b_pin,
    output reg         compare_out_a_en,
    output reg         compare_out_b_en
);

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    reg  [7:0]  compare_wave_control_a_reg;
    reg  [7:0]  clock_capture_control_b_reg;
    reg  [15:0] compare_value_a_reg;
    reg  [15:0] compare_value_b_reg;
    reg  [15:0] compare_buf_a_reg;
    reg  [15:0] compare_buf_b_reg;
    reg  [15:0] capture_value_reg;
    reg  [15:0] count_value_reg;
    reg         count_down_reg;
    reg  [2:0]  flags_reg;
    reg  [1:0]  match_pend_reg;
    reg  [1:0]  wave_out_reg;
    reg  [4:0]  aw_addr_reg;
    reg  [31:0] w_data_reg;
    reg  [3:0]  w_strb_reg;
    reg         aw_have_reg;
    reg         w_have_reg;

    // ------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------
    wire [3:0] wave_mode_sel = {clock_capture_control_b_reg[`TW16_B_WAVE_HI:`TW16_B_WAVE_LO],
        compare_wave_control_a_reg[`TW16_A_WAVE_HI:`TW16_A_WAVE_LO]};          // [R13] [R21]
    wire [1:0] chan_a_output_mode =
        compare_wave_control_a_reg[`TW16_A_MODE_A_HI:`TW16_A_MODE_A_LO];
    wire [1:0] chan_b_output_mode =
        compare_wave_control_a_reg[`TW16_A_MODE_B_HI:`TW16_A_MODE_B_LO];

    wire mode_fast  = (wave_mode_sel == 4'h5) || (wave_mode_sel == 4'h6) ||
                      (wave_mode_sel == 4'h7) || (wave_mode_sel == 4'hE) ||
                      (wave_mode_sel == 4'hF);                                  // [R16] [R20]
    wire mode_pfc   = (wave_mode_sel == 4'h8) || (wave_mode_sel == 4'h9);       // [R18]
    wire mode_pc    = (wave_mode_sel == 4'h1) || (wave_mode_sel == 4'h2) ||
                      (wave_mode_sel == 4'h3) || (wave_mode_sel == 4'hA) ||
                      (wave_mode_sel == 4'hB);                                  // [R15] [R19]
    wire mode_dual  = mode_pc || mode_pfc;
    wire mode_resvd = (wave_mode_sel == 4'hD);                                  // [R13]
    wire mode_immed = !mode_fast && !mode_dual;                                 // [R14] [R17]

    reg [15:0] top_value;
    always @* begin
        case (wave_mode_sel)
            4'h1, 4'h5:       top_value = `TW16_TOP_8BIT;                       // [R15] [R16]
            4'h2, 4'h6:       top_value = `TW16_TOP_9BIT;
            4'h3, 4'h7:       top_value = `TW16_TOP_10BIT;
            4'h4, 4'h9, 4'hB, 4'hF: top_value = compare_value_a_reg;            // [R17] [R18]
            4'h8, 4'hA, 4'hC, 4'hE: top_value = capture_value_reg;              // [R19] [R20]
            default:          top_value = `TW16_MAX;                            // [R14]
        endcase
    end

    wire at_top    = (count_value_reg == top_value);
    wire at_bottom = (count_value_reg == `TW16_RESET_16);
    wire at_max    = (count_value_reg == `TW16_MAX);

    // Compares load from buffers at the boundary of the mode
    wire load_cmp = timer_tick_enable &&
                    ((mode_fast && at_bottom) ||                                // [R20]
                     (mode_pfc && at_bottom) ||                                 // [R2]
                     (mode_pc && at_top));                                      // [R19]

    // Overflow point per mode
    wire ovf_hit = mode_immed ? at_max :
                   mode_fast  ? at_top : (at_bottom && count_down_reg);         // [R14] [R15] [R16]

    // ------------------------------------------------------------
    // Per-channel waveform
    // ------------------------------------------------------------
    wire [1:0]  pin_owned;
    wire [1:0]  wave_next;
    wire [1:0]  match_now;
    genvar ch;
    generate
        for (ch = 0; ch < 2; ch = ch + 1) begin : g_chan
            wire [1:0]  om  = (ch == 0) ? chan_a_output_mode : chan_b_output_mode;
            wire [15:0] cmp = (ch == 0) ? compare_value_a_reg : compare_value_b_reg;
            wire        cur = wave_out_reg[ch];
            wire        tog_ok = (ch == 0) &&
                (mode_fast ? (wave_mode_sel == 4'hE || wave_mode_sel == 4'hF)   // [R9]
                           : (wave_mode_sel == 4'h9 || wave_mode_sel == 4'hB)); // [R12]
            wire        hit = (count_value_reg == cmp);
            reg         nxt;
            assign match_now[ch] = hit;
            assign pin_owned[ch] = (om != `TW16_OM_OFF) && !mode_resvd &&
                ((om != `TW16_OM_TOGGLE) || mode_immed || tog_ok);              // [R4] [R6]
            always @* begin
                nxt = cur;
                if (mode_immed) begin                                           // [R7]
                    if (hit) begin
                        case (om)
                            `TW16_OM_TOGGLE: nxt = !cur;
                            `TW16_OM_CLEAR:  nxt = 1'b0;
                            `TW16_OM_SET:    nxt = 1'b1;
                            default:         nxt = cur;
                        endcase
                    end
                end else if (mode_fast) begin                                   // [R8]
                    if (om[1]) begin
                        if (hit && (cmp != top_value))                          // [R10]
                            nxt = om[0];
                        else if (at_bottom)
                            nxt = !om[0];
                    end else if (om[0] && tog_ok && hit) begin
                        nxt = !cur;
                    end
                end else if (mode_dual) begin                                   // [R11]
                    if (om[1] && hit)
                        nxt = count_down_reg ? !om[0] : om[0];
                    else if (om[0] && tog_ok && hit)
                        nxt = !cur;
                end
            end
            assign wave_next[ch] = nxt;
        end
    endgenerate

    // ------------------------------------------------------------
    // Counter, compare buffers, flags, outputs
    // ------------------------------------------------------------
    wire        wr_fire = aw_have_reg && w_have_reg && !s_axi_bvalid;
    wire [15:0] wdata16 = w_data_reg[15:0];
    wire        wr_flags = wr_fire && (aw_addr_reg == `TW16_OFF_FLAGS) && w_strb_reg[0];
    wire        wr_count = wr_fire && (aw_addr_reg == `TW16_OFF_COUNT);

    always @(posedge aclk) begin
        if (!aresetn) begin
            count_value_reg   <= `TW16_RESET_16;
            count_down_reg    <= 1'b0;
            compare_value_a_reg <= `TW16_RESET_16;
            compare_value_b_reg <= `TW16_RESET_16;
            flags_reg         <= 3'h0;
            match_pend_reg    <= 2'h0;
            wave_out_reg      <= 2'h0;
            compare_out_a_pin <= 1'b0;
            compare_out_b_pin <= 1'b0;
            compare_out_a_en  <= 1'b0;
            compare_out_b_en  <= 1'b0;
        end else begin
            if (timer_tick_enable) begin                                        // [R1]
                wave_out_reg   <= wave_next;
                match_pend_reg <= match_now;
                if (mode_dual) begin
                    if (at_top)
                        count_down_reg <= 1'b1;
                    else if (at_bottom)
                        count_down_reg <= 1'b0;
                    if (at_top || (count_down_reg && !at_bottom))
                        count_value_reg <= count_value_reg - `TW16_ONE;
                    else
                        count_value_reg <= count_value_reg + `TW16_ONE;
                end else begin
                    count_down_reg <= 1'b0;
                    if (at_top)
                        count_value_reg <= `TW16_RESET_16;
                    else
                        count_value_reg <= count_value_reg + `TW16_ONE;
                end
            end
            // A count write is never lost to an idle tick and beats the increment
            if (wr_count)
                count_value_reg <= wdata16;
            if (load_cmp || mode_immed) begin                                   // [R2] [R14]
                compare_value_a_reg <= compare_buf_a_reg;
                compare_value_b_reg <= compare_buf_b_reg;
            end
            // Hardware set wins over a software clear in the same cycle
            flags_reg <= (wr_flags ? (flags_reg & ~w_data_reg[2:0]) : flags_reg) |
                {timer_tick_enable & match_pend_reg[1],                         // [R22]
                 timer_tick_enable & match_pend_reg[0],
                 timer_tick_enable & ovf_hit};                                  // [R1]
            compare_out_a_pin <= wave_out_reg[0];
            compare_out_b_pin <= wave_out_reg[1];
            compare_out_a_en  <= pin_owned[0];                                  // [R4] [R5]
            compare_out_b_en  <= pin_owned[1];
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite write path
    // ------------------------------------------------------------
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `TW16_RESP_OKAY;
            aw_have_reg   <= 1'b0;
            w_have_reg    <= 1'b0;
            aw_addr_reg   <= 5'h00;
            w_data_reg    <= 32'h00000000;
            w_strb_reg    <= 4'h0;
            compare_wave_control_a_reg  <= `TW16_RESET_8;
            clock_capture_control_b_reg <= `TW16_RESET_8;
            compare_buf_a_reg <= `TW16_RESET_16;
            compare_buf_b_reg <= `TW16_RESET_16;
            capture_value_reg <= `TW16_RESET_16;
        end else begin
            s_axi_awready <= !aw_have_reg && !s_axi_awready && s_axi_awvalid;
            s_axi_wready  <= !w_have_reg && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr_reg <= s_axi_awaddr;
                aw_have_reg <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
                w_have_reg <= 1'b1;
            end
            if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
            if (wr_fire) begin
                aw_have_reg  <= 1'b0;
                w_have_reg   <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= `TW16_RESP_OKAY;
                if (aw_addr_reg == `TW16_OFF_CTRL_A) begin
                    if (w_strb_reg[0])
                        compare_wave_control_a_reg <= w_data_reg[7:0] & `TW16_A_WR_MASK; // [R3]
                end else if (aw_addr_reg == `TW16_OFF_CTRL_B) begin
                    if (w_strb_reg[0])
                        clock_capture_control_b_reg <= w_data_reg[7:0] & `TW16_B_WR_MASK;
                end else if (aw_addr_reg == `TW16_OFF_CMP_A) begin
                    if (w_strb_reg[0]) compare_buf_a_reg[7:0]  <= w_data_reg[7:0];
                    if (w_strb_reg[1]) compare_buf_a_reg[15:8] <= w_data_reg[15:8];
                end else if (aw_addr_reg == `TW16_OFF_CMP_B) begin
                    if (w_strb_reg[0]) compare_buf_b_reg[7:0]  <= w_data_reg[7:0];
                    if (w_strb_reg[1]) compare_buf_b_reg[15:8] <= w_data_reg[15:8];
                end else if (aw_addr_reg == `TW16_OFF_CAPTURE) begin
                    if (w_strb_reg[0]) capture_value_reg[7:0]  <= w_data_reg[7:0];
                    if (w_strb_reg[1]) capture_value_reg[15:8] <= w_data_reg[15:8];
                end else if (aw_addr_reg == `TW16_OFF_COUNT ||
                             aw_addr_reg == `TW16_OFF_FLAGS) begin
                    s_axi_bresp <= `TW16_RESP_OKAY;
                end else begin
                    s_axi_bresp <= `TW16_RESP_SLVERR;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite read path
    // ------------------------------------------------------------
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `TW16_RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
            if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= `TW16_RESP_OKAY;
                if (s_axi_araddr == `TW16_OFF_CTRL_A)
                    s_axi_rdata <= {24'h000000, compare_wave_control_a_reg};
                else if (s_axi_araddr == `TW16_OFF_CTRL_B)
                    s_axi_rdata <= {24'h000000, clock_capture_control_b_reg};
                else if (s_axi_araddr == `TW16_OFF_CMP_A)
                    s_axi_rdata <= {16'h0000, compare_buf_a_reg};
                else if (s_axi_araddr == `TW16_OFF_CMP_B)
                    s_axi_rdata <= {16'h0000, compare_buf_b_reg};
                else if (s_axi_araddr == `TW16_OFF_CAPTURE)
                    s_axi_rdata <= {16'h0000, capture_value_reg};
                else if (s_axi_araddr == `TW16_OFF_COUNT)
                    s_axi_rdata <= {16'h0000, count_value_reg};
                else if (s_axi_araddr == `TW16_OFF_FLAGS)
                    s_axi_rdata <= {29'h00000000, flags_reg};
                else begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= `TW16_RESP_SLVERR;
                end
            end
        end
    end

endmodule // tw16_wave_ctrl

// file: src/tw16_regs.vh
`ifndef TW16_REGS_VH
`define TW16_REGS_VH
// ------------------------------------------------------------
// Register offsets (byte addresses)
// ------------------------------------------------------------
`define TW16_OFF_CTRL_A    5'h00
`define TW16_OFF_CTRL_B    5'h04
`define TW16_OFF_CMP_A     5'h08
`define TW16_OFF_CMP_B     5'h0C
`define TW16_OFF_CAPTURE   5'h10
`define TW16_OFF_COUNT     5'h14
`define TW16_OFF_FLAGS     5'h18
// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define TW16_A_MODE_A_HI   7
`define TW16_A_MODE_A_LO   6
`define TW16_A_MODE_B_HI   5
`define TW16_A_MODE_B_LO   4
`define TW16_A_WAVE_HI     1
`define TW16_A_WAVE_LO     0
`define TW16_B_WAVE_HI     4
`define TW16_B_WAVE_LO     3
`define TW16_B_WR_MASK     8'hDF
`define TW16_A_WR_MASK     8'hF3
`define TW16_FLAG_OVF      0
`define TW16_FLAG_MATCH_A  1
`define TW16_FLAG_MATCH_B  2
// ------------------------------------------------------------
// Constants
// ------------------------------------------------------------
`define TW16_RESET_8       8'h00
`define TW16_RESET_16      16'h0000
`define TW16_MAX           16'hFFFF
`define TW16_TOP_8BIT      16'h00FF
`define TW16_TOP_9BIT      16'h01FF
`define TW16_TOP_10BIT     16'h03FF
`define TW16_ONE           16'h0001
`define TW16_OM_OFF        2'h0
`define TW16_OM_TOGGLE     2'h1
`define TW16_OM_CLEAR      2'h2
`define TW16_OM_SET        2'h3
`define TW16_RESP_OKAY     2'h0
`define TW16_RESP_SLVERR   2'h2
`endif

// file: verification/tw16_pin_pad.sv
`timescale 1ns/1ps
// ----
// Pin pad beyond a compare output
// ----
module tw16_pin_pad (
    // Waveform side
    input  wire drive_en,
    input  wire drive_val,
    // Port direction set by software
    input  wire dir_out,
    // Board side, pulled up
    output wire pad
);
    // Without the direction bit the driver stays off and the pull-up wins
    assign pad = (drive_en && dir_out) ? drive_val : 1'b1;
endmodule // tw16_pin_pad

// file: verification/tw16_wave_chk.sv
`timescale 1ns/1ps
`include "tw16_regs.vh"
module tw16_wave_chk (
    // Clock and reset
    input wire        aclk,
    input wire        aresetn,
    // Register bus
    input wire [4:0]  s_axi_awaddr,
    input wire        s_axi_awvalid,
    input wire        s_axi_awready,
    input wire        s_axi_wvalid,
    input wire        s_axi_wready,
    input wire [1:0]  s_axi_bresp,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire [4:0]  s_axi_araddr,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0]  s_axi_rresp,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready,
    // Timer and pins
    input wire        timer_tick_enable,
    input wire        compare_out_a_pin,
    input wire        compare_out_b_pin
);
    // ----
    // Helper state
    // ----
    logic       wr_bad_reg;
    logic       rd_bad_reg;
    logic [1:0] quiet_reg;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_bad_reg <= 1'b0;
            rd_bad_reg <= 1'b0;
            quiet_reg  <= 2'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) wr_bad_reg <= (s_axi_awaddr > 5'h18);
            if (s_axi_arvalid && s_axi_arready) rd_bad_reg <= (s_axi_araddr > 5'h18);
            // Saturates once the lagging pin update has landed
            if (timer_tick_enable) quiet_reg <= 2'h0;
            else if (quiet_reg != 2'h3) quiet_reg <= quiet_reg + 2'h1;
        end
    end
    // ----
    // Properties
    // ----
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    chk_aw_ready_pulse: assert property (s_axi_awready |=> !s_axi_awready)
        else $error("awready too long");
    chk_aw_needs_valid: assert property (s_axi_awready |-> s_axi_awvalid)
        else $error("awready without awvalid");
    chk_b_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("bvalid dropped");
    chk_r_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("rvalid dropped");
    chk_r_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    chk_b_latency: assert property (s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
        else $error("write response late");
    chk_wr_resp_code: assert property (s_axi_bvalid |->
        s_axi_bresp == (wr_bad_reg ? `TW16_RESP_SLVERR : `TW16_RESP_OKAY))
        else $error("bad bresp");
    chk_rd_unmapped: assert property (s_axi_rvalid && rd_bad_reg |->
        s_axi_rresp == `TW16_RESP_SLVERR && s_axi_rdata == 32'h0)
        else $error("unmapped read ok");
    chk_pins_quiet: assert property (quiet_reg == 2'h3 |->
        $stable(compare_out_a_pin) && $stable(compare_out_b_pin))
        else $error("pin moved untimed");
    cov_write: cover property (s_axi_bvalid && s_axi_bready);
    cov_read: cover property (s_axi_rvalid && s_axi_rready);
    cov_pin_rise: cover property ($rose(compare_out_a_pin));
    cov_refused: cover property (s_axi_rvalid && rd_bad_reg);
endmodule // tw16_wave_chk
bind tw16_wave_ctrl tw16_wave_chk u_chk (.*);

// file: verification/timer16_waveform_mode_control_bench.sv
`timescale 1ns/1ps
`include "tw16_regs.vh"
module timer16_waveform_mode_control_bench;
    // ----
    // Signals and instances
    // ----
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [4:0]  awaddr = 5'h00, araddr = 5'h00;
    logic [31:0] wdata = 32'h0, rd;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        tick = 1'b0, dir_out = 1'b1;
    logic [1:0]  rsp;
    wire         awready, wready, bvalid, arready, rvalid, pin_a, pin_b, en_a, en_b, pad_a, pad_b;
    wire  [1:0]  bresp, rresp;
    wire  [31:0] rdata;
    int          n_errors = 0, comparisons = 0;
    always #10 aclk = ~aclk;
    tw16_wave_ctrl u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .timer_tick_enable(tick), .compare_out_a_pin(pin_a), .compare_out_b_pin(pin_b),
        .compare_out_a_en(en_a), .compare_out_b_en(en_b));
    tw16_pin_pad u_pad_a (.drive_en(en_a), .drive_val(pin_a), .dir_out(dir_out), .pad(pad_a));
    tw16_pin_pad u_pad_b (.drive_en(en_b), .drive_val(pin_b), .dir_out(dir_out), .pad(pad_b));
    // ----
    // Shared tasks
    // ----
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic axi_wr(input logic [4:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        rsp = bresp;
        bready <= 1'b0;
    endtask
    task automatic axi_rd(input logic [4:0] a);
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rd = rdata;
        rsp = rresp;
        rready <= 1'b0;
    endtask
    task automatic rd_chk(input logic [4:0] a, input logic [31:0] exp);
        axi_rd(a);
        check(rd, exp);
    endtask
    task automatic ticks(input int n);
        tick <= 1'b1;
        repeat (n) @(posedge aclk);
        tick <= 1'b0;
    endtask
    task automatic setup(input logic [3:0] w, input logic [15:0] ca, cb, cap,
                         input logic [1:0] oa, ob);
        axi_wr(`TW16_OFF_CAPTURE, {16'h0, cap});
        axi_wr(`TW16_OFF_CMP_A, {16'h0, ca});
        axi_wr(`TW16_OFF_CMP_B, {16'h0, cb});
        axi_wr(`TW16_OFF_CTRL_B, {27'h0, w[3:2], 3'h0});
        axi_wr(`TW16_OFF_CTRL_A, {24'h0, oa, ob, 2'h0, w[1:0]});
    endtask
    // High pad samples over a period, slack for the pin lag
    task automatic duty(input logic [3:0] w, input logic [15:0] ca, cb, cap,
                        input logic [1:0] oa, ob, input int per, ea, eb);
        int ha, hb;
        ha = 0;
        hb = 0;
        setup(w, ca, cb, cap, oa, ob);
        axi_wr(`TW16_OFF_COUNT, 32'h0);
        tick <= 1'b1;
        repeat (2 * per) @(posedge aclk);
        repeat (per) begin
            @(posedge aclk);
            ha += (pad_a === 1'b1);
            hb += (pad_b === 1'b1);
        end
        tick <= 1'b0;
        check(32'((ha - ea <= 3 && ea - ha <= 3) ? ea : ha), 32'(ea));
        check(32'((hb - eb <= 3 && eb - hb <= 3) ? eb : hb), 32'(eb));
        axi_rd(`TW16_OFF_FLAGS);
        check({31'h0, rd[0]}, 32'h1);
        axi_wr(`TW16_OFF_FLAGS, 32'h7);
    endtask
    // ----
    // Scenarios
    // ----
    task automatic t_regs();
        rd_chk(`TW16_OFF_CTRL_A, 32'h0);
        rd_chk(`TW16_OFF_CTRL_B, 32'h0);
        rd_chk(`TW16_OFF_FLAGS, 32'h0);
        axi_rd(5'h1C);
        check({rd[29:0], rsp}, {30'h0, `TW16_RESP_SLVERR});
        axi_wr(`TW16_OFF_CTRL_A, 32'hFF);
        rd_chk(`TW16_OFF_CTRL_A, 32'hF3);
        axi_wr(`TW16_OFF_CTRL_B, 32'hFF);
        rd_chk(`TW16_OFF_CTRL_B, 32'hDF);
        check({en_a, en_b}, 32'h3);
        axi_wr(`TW16_OFF_CTRL_B, 32'h0);
        axi_wr(`TW16_OFF_CTRL_A, 32'h0);
        repeat (2) @(posedge aclk);
        check({en_a, en_b}, 32'h0);
    endtask
    task automatic t_tick();
        axi_wr(`TW16_OFF_COUNT, 32'h100);
        ticks(1);
        rd_chk(`TW16_OFF_COUNT, 32'h101);
        repeat (5) @(posedge aclk);
        rd_chk(`TW16_OFF_COUNT, 32'h101);
        ticks(3);
        rd_chk(`TW16_OFF_COUNT, 32'h104);
    endtask
    task automatic t_nonpwm();
        logic [1:0] om [3] = '{2'h3, 2'h1, 2'h2};
        logic       ex [3] = '{1'b1, 1'b0, 1'b0};
        for (int i = 0; i < 3; i++) begin
            setup(4'h0, 16'h20, 16'h20, 16'h0, om[i], om[i]);
            axi_wr(`TW16_OFF_COUNT, 32'h1E);
            ticks(6);
            repeat (3) @(posedge aclk);
            check({pad_a, pad_b, en_a, en_b}, {ex[i], ex[i], 2'h3});
            rd_chk(`TW16_OFF_FLAGS, 32'h6);
            axi_wr(`TW16_OFF_FLAGS, 32'h7);
        end
        dir_out <= 1'b0;
        @(posedge aclk);
        check({pad_a, pad_b}, 32'h3);
        dir_out <= 1'b1;
    endtask
    task automatic t_ovf();
        setup(4'h4, 16'h20, 16'h100, 16'h0, 2'h0, 2'h0);
        axi_wr(`TW16_OFF_COUNT, 32'h1E);
        ticks(5);
        axi_rd(`TW16_OFF_COUNT);
        check({31'h0, rd < 32'h8}, 32'h1);
        rd_chk(`TW16_OFF_FLAGS, 32'h2);
        axi_wr(`TW16_OFF_FLAGS, 32'h7);
        axi_wr(`TW16_OFF_CTRL_B, 32'h0);
        axi_wr(`TW16_OFF_COUNT, 32'hFFFD);
        ticks(5);
        rd_chk(`TW16_OFF_FLAGS, 32'h1);
        axi_wr(`TW16_OFF_FLAGS, 32'h7);
    endtask
    task automatic t_toggle();
        logic [3:0] md [7] = '{4'h5, 4'hF, 4'h1, 4'h9, 4'hB, 4'hE, 4'hD};
        logic       ea [7] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
        for (int i = 0; i < 7; i++) begin
            axi_wr(`TW16_OFF_CTRL_B, {27'h0, md[i][3:2], 3'h0});
            axi_wr(`TW16_OFF_CTRL_A, {24'h0, 4'h5, 2'h0, md[i][1:0]});
            repeat (2) @(posedge aclk);
            check({en_a, en_b}, {ea[i], 1'b0});
        end
    endtask
    // ----
    // Sequence and verdict
    // ----
    task automatic close_out();
        $display("Errors: %0d, comparisons: %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs();
        t_tick();
        t_nonpwm();
        t_ovf();
        duty(4'h5, 16'h40, 16'hFF, 16'h0, 2'h2, 2'h2, 256, 65, 256);
        duty(4'h5, 16'h40, 16'h80, 16'h0, 2'h3, 2'h2, 256, 191, 129);
        duty(4'h1, 16'h40, 16'h40, 16'h0, 2'h2, 2'h3, 510, 128, 382);
        duty(4'h8, 16'h20, 16'h20, 16'h80, 2'h2, 2'h3, 256, 64, 192);
        duty(4'hE, 16'h10, 16'h10, 16'h7F, 2'h2, 2'h3, 128, 17, 111);
        t_toggle();
        close_out();
    end
    initial begin
        #400000;
        n_errors++;
        close_out();
    end
endmodule // timer16_waveform_mode_control_bench
